// ==== src/agc_loop_pkg.sv ====
package agc_loop_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices (word addresses on the plain port)
   localparam logic [3:0] ADDR_THRESH_GAINS = 4'h8;
   localparam logic [3:0] ADDR_LIMITS       = 4'h9;
   localparam logic [3:0] ADDR_SAMPLE_STB   = 4'ha;
   localparam logic [3:0] ADDR_SAMPLED_GAIN = 4'hb;
   localparam logic [3:0] ADDR_LIVE_GAIN    = 4'hc;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int SYNC_LOAD_BIT  = 29;
   localparam int THRESH_MSB     = 28;
   localparam int THRESH_LSB     = 16;
   localparam int SET1_MANT_MSB  = 15;
   localparam int SET1_MANT_LSB  = 12;
   localparam int SET1_EXP_MSB   = 11;
   localparam int SET1_EXP_LSB   = 8;
   localparam int SET0_MANT_MSB  = 7;
   localparam int SET0_MANT_LSB  = 4;
   localparam int SET0_EXP_MSB   = 3;
   localparam int SET0_EXP_LSB   = 0;
   localparam int UPPER_MSB      = 27;
   localparam int UPPER_LSB      = 16;
   localparam int LOWER_MSB      = 11;
   localparam int LOWER_LSB      = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and masks
   localparam logic [31:0] THRESH_GAINS_RESET = 32'h0000_0000;
   localparam logic [31:0] LIMITS_RESET       = 32'h0fff_0000;
   localparam logic [31:0] THRESH_GAINS_MASK  = 32'h3fff_ffff;
   localparam logic [31:0] LIMITS_MASK        = 32'h0fff_0fff;
   localparam logic [11:0] GAIN_RESET         = 12'h000;

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic widths
   localparam int GAIN_W  = 12;
   localparam int FRAC_W  = 16;
   localparam int ACC_W   = GAIN_W + FRAC_W;
   localparam int MAG_W   = 13;
   localparam int SHIFT_BASE = 15;

endpackage

// ==== src/agc_loop_config.sv ====
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module agc_loop_config
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_ce,
   input  wire logic [3:0]            i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [31:0]           o_rdata,
   input  wire logic                  i_filter_sync_pin,
   input  wire logic                  i_loop_gain_set_select,
   input  wire logic                  i_sample_valid,
   input  wire logic [12:0]           i_magnitude,
   output logic      [11:0]           o_gain,
   output logic      [11:0]           o_sampled_gain
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [31:0]                       thresh_gains;
   logic [31:0]                       limits;
   logic [27:0]                       acc;
   logic [11:0]                       sampled;
   logic [31:0]                       rdata;
   logic [1:0]                        sync_meta;
   logic [1:0]                        sel_meta;
   logic                              sync_prev;
   logic [31:0]                       next_thresh_gains;
   logic [31:0]                       next_limits;
   logic [27:0]                       next_acc;
   logic [11:0]                       next_sampled;
   logic [31:0]                       next_rdata;
   logic                              next_sync_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Saturate a wide signed value into the limit window
   function automatic logic [27:0] clamp(input logic signed [31:0] v,
                                          input logic [11:0] lo,
                                          input logic [11:0] hi);
      logic signed [31:0] lo_w;
      logic signed [31:0] hi_w;
      lo_w = $signed({4'h0, lo, 16'h0000});
      hi_w = $signed({4'h0, hi, 16'h0000});
      if (v < lo_w)
         clamp = lo_w[27:0];
      else if (v > hi_w)
         clamp = hi_w[27:0];
      else
         clamp = v[27:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Loop arithmetic
   logic [3:0]                        mant;
   logic [3:0]                        expo;
   logic signed [14:0]                gain_err;
   logic signed [31:0]                step;
   logic signed [31:0]                sum;
   logic [11:0]                       upper;
   logic [11:0]                       lower;
   logic                              sync_edge;

   always_comb
   begin
      upper = limits[agc_loop_pkg::UPPER_MSB:agc_loop_pkg::UPPER_LSB];
      lower = limits[agc_loop_pkg::LOWER_MSB:agc_loop_pkg::LOWER_LSB];
      if (sel_meta[1])
      begin
         mant = thresh_gains[agc_loop_pkg::SET1_MANT_MSB:agc_loop_pkg::SET1_MANT_LSB];
         expo = thresh_gains[agc_loop_pkg::SET1_EXP_MSB:agc_loop_pkg::SET1_EXP_LSB];
      end
      else
      begin
         mant = thresh_gains[agc_loop_pkg::SET0_MANT_MSB:agc_loop_pkg::SET0_MANT_LSB];
         expo = thresh_gains[agc_loop_pkg::SET0_EXP_MSB:agc_loop_pkg::SET0_EXP_LSB];
      end
      gain_err = $signed({{2{thresh_gains[agc_loop_pkg::THRESH_MSB]}},
                 thresh_gains[agc_loop_pkg::THRESH_MSB:agc_loop_pkg::THRESH_LSB]})
                 - $signed({2'b00, i_magnitude});
      // Error times mantissa times 16 in accumulator fractional units, then shifted right by 15 minus the exponent
      step = (32'(gain_err) * $signed({28'h0000000, mant})) <<< 4;
      step = step >>> (4'(agc_loop_pkg::SHIFT_BASE) - expo);
      sum = $signed({4'h0, acc}) + step;
      sync_edge = sync_meta[1] & ~sync_prev;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      next_thresh_gains = thresh_gains;
      next_limits = limits;
      next_acc = acc;
      next_sampled = sampled;
      next_rdata = 32'h0000_0000;
      next_sync_prev = sync_meta[1];
      if (i_wr)
      begin
         unique case (i_addr)
            agc_loop_pkg::ADDR_THRESH_GAINS:
               next_thresh_gains = i_wdata & agc_loop_pkg::THRESH_GAINS_MASK;
            agc_loop_pkg::ADDR_LIMITS:
               next_limits = i_wdata & agc_loop_pkg::LIMITS_MASK;
            agc_loop_pkg::ADDR_SAMPLE_STB:
               next_sampled = acc[27:16];
            default:
               next_sampled = sampled;
         endcase
      end
      if (i_rd)
      begin
         unique case (i_addr)
            agc_loop_pkg::ADDR_THRESH_GAINS: next_rdata = thresh_gains;
            agc_loop_pkg::ADDR_LIMITS:       next_rdata = limits;
            agc_loop_pkg::ADDR_SAMPLED_GAIN: next_rdata = {20'h00000, sampled};
            agc_loop_pkg::ADDR_LIVE_GAIN:    next_rdata = {20'h00000, acc[27:16]};
            default:                         next_rdata = 32'h0000_0000;
         endcase
      end
      if (sync_edge && thresh_gains[agc_loop_pkg::SYNC_LOAD_BIT])
         next_acc = clamp($signed({4'h0, acc[27:16], 16'h0000}), lower, upper);
      else if (i_sample_valid)
         next_acc = clamp(sum, lower, upper);
      else
         next_acc = clamp($signed({4'h0, acc}), lower, upper);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers, all on the processing clock
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         thresh_gains <= agc_loop_pkg::THRESH_GAINS_RESET;
         limits <= agc_loop_pkg::LIMITS_RESET;
         acc <= 28'h0000000;
         sampled <= agc_loop_pkg::GAIN_RESET;
         rdata <= 32'h0000_0000;
         sync_meta <= 2'h0;
         sel_meta <= 2'h0;
         sync_prev <= 1'b0;
         o_gain <= agc_loop_pkg::GAIN_RESET;
      end
      else if (i_ce)
      begin
         thresh_gains <= next_thresh_gains;
         limits <= next_limits;
         acc <= next_acc;
         sampled <= next_sampled;
         rdata <= next_rdata;
         sync_meta <= {sync_meta[0], i_filter_sync_pin};
         sel_meta <= {sel_meta[0], i_loop_gain_set_select};
         sync_prev <= next_sync_prev;
         o_gain <= next_acc[27:16];
      end
   end

   assign o_rdata = rdata;
   assign o_sampled_gain = sampled;

endmodule

// ==== verif/agc_loop_config_properties.sv ====
`timescale 1ns/1ps
module agc_loop_config_check
(
   input wire logic        i_clk,
   input wire logic        i_rst,
   input wire logic        i_ce,
   input wire logic [3:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_filter_sync_pin,
   input wire logic        i_loop_gain_set_select,
   input wire logic        i_sample_valid,
   input wire logic [12:0] i_magnitude,
   input wire logic [11:0] o_gain,
   input wire logic [11:0] o_sampled_gain
);
   logic [31:0] cfg;
   logic [31:0] lim;
   logic [2:0]  quiet;
   logic        ev;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////
   // Shadow of the writable words and a count of quiet cycles
   assign ev = i_sample_valid || i_wr || i_filter_sync_pin;
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cfg   <= 32'h0;
         lim   <= 32'h0fff_0000;
         quiet <= 3'h0;
      end
      else
      begin
         if (i_ce && i_wr && i_addr == 4'h8) cfg <= i_wdata & 32'h3fff_ffff;
         if (i_ce && i_wr && i_addr == 4'h9) lim <= i_wdata & 32'h0fff_0fff;
         if (ev) quiet <= 3'h0;
         else if (quiet != 3'h7) quiet <= quiet + 3'h1;
      end
   end
   ////////////////////
   rd_idle_a: assert property (!$past(i_rd && i_ce) |-> o_rdata == 32'h0)
      else $error("read data not idle");
   rd_cfg_a: assert property (i_rd && i_ce && i_addr == 4'h8 |=> o_rdata == $past(cfg))
      else $error("config readback");
   rd_lim_a: assert property (i_rd && i_ce && i_addr == 4'h9 |=> o_rdata == $past(lim))
      else $error("limit readback");
   rd_held_a: assert property (i_rd && i_ce && i_addr == 4'hb |=>
      o_rdata == {20'h0, $past(o_sampled_gain)}) else $error("held readback");
   gain_lim_a: assert property ($past(i_sample_valid && i_ce, 2) |->
      o_gain <= lim[27:16] && o_gain >= lim[11:0]) else $error("gain out of range");
   gain_hold_a: assert property (quiet > 3'h3 && !ev |=> $stable(o_gain))
      else $error("gain moved");
   held_keep_a: assert property (quiet > 3'h3 && !ev |=> $stable(o_sampled_gain))
      else $error("held gain moved");
   ce_freeze_a: assert property (!i_ce |=> $stable(o_gain) && $stable(o_sampled_gain))
      else $error("state moved");
   cover property (i_sample_valid && i_loop_gain_set_select);
   cover property (i_sample_valid && !i_ce);
   cover property (i_filter_sync_pin && cfg[29]);
endmodule
bind agc_loop_config agc_loop_config_check i_check (.*);

// ==== verif/agc_loop_config_test.sv ====
`timescale 1ns/1ps
module agc_loop_config_test;
   logic        i_clk = 1'h0, i_rst = 1'h1, i_ce = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
   logic        i_filter_sync_pin = 1'h0, i_loop_gain_set_select = 1'h0, i_sample_valid = 1'h0;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0, o_rdata, cfg = 32'h0, lim;
   logic [12:0] i_magnitude = 13'h0;
   logic [11:0] o_gain, o_sampled_gain;
   longint      acc = 0;
   int          n_errors = 0, cmp_count = 0;
   always #50 i_clk = ~i_clk;
   agc_loop_config i_dut (.*);
   ////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      cmp_count++;
      if (got !== want)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'h0;
      i_rd <= 1'h0;
      #1;
   endtask
   task automatic step(input logic [12:0] m, input logic c);
      logic [3:0] mt, ex;
      longint     top;
      longint     bottom;
      {mt, ex} = i_loop_gain_set_select ? cfg[15:8] : cfg[7:0];
      top = longint'(lim[27:16]) <<< 16;
      bottom = longint'(lim[11:0]) <<< 16;
      @(posedge i_clk);
      i_sample_valid <= 1'h1;
      i_magnitude <= m;
      i_ce <= c;
      @(posedge i_clk);
      i_sample_valid <= 1'h0;
      i_ce <= 1'h1;
      if (c) acc += ((longint'($signed(cfg[28:16])) - int'(m)) * int'(mt) * 16) >>> (15 - ex);
      if (acc < bottom) acc = bottom;
      if (acc > top) acc = top;
      repeat (2) @(posedge i_clk);
      #1 chk({20'h0, o_gain}, {20'h0, acc[27:16]});
   endtask
   task automatic end_sim;
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////
   initial
   begin
      void'($urandom(66614));
      lim = {4'h0, 12'h800 | 12'($urandom), 4'h0, 12'h0ff & 12'($urandom)};
      repeat (10) @(posedge i_clk);
      i_rst <= 1'h0;
      bus(1'h0, 4'h9, 32'h0);
      chk(o_rdata, 32'h0fff_0000);
      bus(1'h1, 4'h9, lim);
      acc = longint'(lim[11:0]) <<< 16;
      for (int k = 0; k < 80; k++)
      begin
         if (k % 10 == 0)
         begin
            cfg = $urandom & 32'h3fff_ffff;
            bus(1'h1, 4'h8, cfg);
            bus(1'h0, 4'h8, 32'h0);
            chk(o_rdata, cfg);
            bus(1'h0, 4'h9, 32'h0);
            chk(o_rdata, lim);
         end
         @(posedge i_clk);
         i_loop_gain_set_select <= 1'($urandom);
         repeat (3) @(posedge i_clk);
         step(13'($urandom), k % 9 != 4);
         if (k % 7 == 3)
         begin
            @(posedge i_clk);
            i_filter_sync_pin <= 1'h1;
            @(posedge i_clk);
            i_filter_sync_pin <= 1'h0;
            if (cfg[29]) acc = acc & ~longint'(65535);
            repeat (5) @(posedge i_clk);
         end
         if (k % 5 == 2)
         begin
            bus(1'h1, 4'ha, $urandom);
            bus(1'h0, 4'hb, 32'h0);
            chk(o_rdata, {20'h0, acc[27:16]});
            chk({20'h0, o_sampled_gain}, {20'h0, acc[27:16]});
            bus(1'h0, 4'hc, 32'h0);
            chk(o_rdata, {20'h0, acc[27:16]});
            bus(1'h0, 4'h3, 32'h0);
            chk(o_rdata, 32'h0);
         end
      end
      end_sim;
   end
endmodule
